// ---- amcr_consts.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef AMCR_CONSTS_SVH
`define AMCR_CONSTS_SVH

`define AMCR_ADDR_W          4
`define AMCR_OFF_OPER        4'h2
`define AMCR_OFF_CLK         4'h3
`define AMCR_OFF_GAIN        4'h4
`define AMCR_OFF_STAT        4'h1
`define AMCR_RST_OPER        16'h0510
`define AMCR_RST_CLK         16'hff0e
`define AMCR_RST_GAIN        16'h0000
`define AMCR_MASK_OPER       16'h3f1f
`define AMCR_MASK_CLK        16'hffdf
`define AMCR_MASK_GAIN       16'h7777
`define AMCR_BIT_REGCRC      13
`define AMCR_BIT_RXCRC       12
`define AMCR_BIT_CRCTYPE     11
`define AMCR_BIT_RSTFLAG     10
`define AMCR_BIT_TIMEOUT     4
`define AMCR_BIT_FLOAT       1
`define AMCR_BIT_PULSEFMT    0
`define AMCR_BIT_OSCOFF      7
`define AMCR_BIT_EXTREF      6
`define AMCR_SRC_LAG         2'h0
`define AMCR_SRC_OR          2'h1
`define AMCR_PULSE_NS        40
`define AMCR_CLK_NS          20
`define AMCR_PULSE_CYC       ((`AMCR_PULSE_NS + `AMCR_CLK_NS - 1) / `AMCR_CLK_NS)

`endif

// ---- amcr_core_model.sv ----
// Converter-core stand-in: free conversion tick, staggered channel ready
module amcr_core_model (
  // Clock and controls
  input  wire logic  i_core_clk,
  input  wire logic  i_go,
  input  wire logic  i_taken,
  // Core side
  output logic       o_tick,
  output logic [7:0] o_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rdy_reg = 8'h00;
  assign o_ready = rdy_reg;
  // Tick at 160 ns, phase offset so it never lines up with the core clock
  initial begin
    o_tick = 1'b0;
    #37;
    forever #80 o_tick = ~o_tick;
  end
  // Channels finish one per cycle, lowest first; a host read clears all
  always @(posedge i_core_clk) begin
    if (i_taken) rdy_reg <= 8'h00;
    else if (i_go) rdy_reg <= 8'h01;
    else if (rdy_reg != 8'h00) rdy_reg <= {rdy_reg[6:0], 1'b1};
  end
endmodule // amcr_core_model

// ---- amcr_pkg.sv ----
// Types shared by the configuration register bank
package amcr_pkg;

  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic       map_crc_en;
    logic       frame_crc_en;
    logic       crc_poly_ansi;
    logic       reset_flag;
    logic [1:0] word_size_select;
    logic [2:0] rsvd_mid;
    logic       timeout_en;
    logic [1:0] ready_source_select;
    logic       ready_idle_float;
    logic       ready_pulse_format;
  } amcr_oper_t;

  typedef struct packed {
    logic [7:0] channel_enable;
    logic       oscillator_off;
    logic       outside_reference_select;
    logic       rsvd;
    logic [2:0] oversampling_ratio;
    logic [1:0] power_profile;
  } amcr_clk_t;

  typedef struct packed {
    logic [3:0][3:0] amp_gain;
  } amcr_gain_t;

  // Decoded settings for the converter core
  typedef struct packed {
    logic        map_crc_en;
    logic        frame_crc_en;
    logic        crc_poly_ansi;
    logic [5:0]  word_bits;
    logic        word_sign_ext;
    logic        timeout_en;
    logic [7:0]  channel_enable;
    logic        oscillator_off;
    logic        outside_reference_select;
    logic [14:0] osr_value;
    logic [1:0]  power_profile;
    logic [3:0][7:0] amp_gain_factor;
  } amcr_cfg_t;

  typedef enum logic [1:0] {
    AMCR_RDY_IDLE  = 2'b00,
    AMCR_RDY_PULSE = 2'b10,
    AMCR_RDY_HOLD  = 2'b01
  } amcr_rdy_state_t;

endpackage

// ---- amcr_ready_pin.sv ----
// Data-ready pin driver: level or fixed low pulse, idle high or floating
`include "amcr_consts.svh"

module amcr_ready_pin #(
  parameter int PULSE_CYC = `AMCR_PULSE_CYC
) (
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  // Control
  input  wire logic i_new_data,
  input  wire logic i_data_taken,
  input  wire logic i_pulse_format,
  input  wire logic i_idle_float,
  // Pin
  output logic      o_pin_out,
  output logic      o_pin_oe
);

  typedef struct packed {
    amcr_pkg::amcr_rdy_state_t st;
    logic [7:0]                cnt;
  } amcr_rdy_regs_t;

  amcr_rdy_regs_t st_reg;
  amcr_rdy_regs_t st_next;

  // Next state of the pin machine
  always_comb begin
    st_next = st_reg;
    unique case (st_reg.st)
      amcr_pkg::AMCR_RDY_IDLE: begin
        if (i_new_data) begin
          st_next.cnt = 8'h00;
          st_next.st  = i_pulse_format ? amcr_pkg::AMCR_RDY_PULSE : amcr_pkg::AMCR_RDY_HOLD;
        end
      end
      amcr_pkg::AMCR_RDY_PULSE: begin
        st_next.cnt = st_reg.cnt + 8'h01;
        if (st_reg.cnt == 8'(PULSE_CYC - 1)) begin
          st_next.st = amcr_pkg::AMCR_RDY_IDLE;
        end
      end
      amcr_pkg::AMCR_RDY_HOLD: begin
        if (i_data_taken) begin
          st_next.st = amcr_pkg::AMCR_RDY_IDLE;
        end
      end
      default: st_next.st = amcr_pkg::AMCR_RDY_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Low while pulsing or holding; idle is high or released
  always_comb begin
    o_pin_out = (st_reg.st == amcr_pkg::AMCR_RDY_IDLE);      // [R9]
    o_pin_oe  = !(o_pin_out && i_idle_float);                 // [R8]
  end

endmodule // amcr_ready_pin

// ---- amcr_regs.sv ----
// Operating, clock and low-channel gain configuration registers
`include "amcr_consts.svh"

// What this block does
// [R1] Operating bit 13 enables register-map CRC
// [R2] Operating bit 12 enables incoming frame CRC
// [R3] Bit 11 picks CCITT or ANSI polynomial
// [R4] Writing bit 10 low clears reset flag
// [R5] Bits 9:8 choose 16/24/32 word size
// [R6] Bit 4 enables serial timeout, default on
// [R7] Bits 3:2 choose data-ready source
// [R8] Bit 1 floats data-ready pin when idle
// [R9] Bit 0 picks held low or pulse
// [R10] Clock bits 15:8 enable channels 7..0
// [R11] Clock bit 7 turns oscillator off
// [R12] Clock bit 6 selects external reference
// [R13] Bits 4:2 set oversampling ratio
// [R14] Bits 1:0 set power profile
// [R15] Clock register at 03h, resets FF0Eh
// [R16] Gain register at 4h, resets 0000h
// [R17] Operating register at 02h, resets 0510h
// [R18] Gain code gives two to the code
// [R19] Status reset flag set until host clears
// [R20] Reserved fields reset and hold zero
// [R21] Sixteen-bit registers, reads without side effects
module amcr_regs (
  // Clock and reset
  input  wire logic                     i_core_clk,
  input  wire logic                     i_rst_n,
  // Register port
  input  wire logic [`AMCR_ADDR_W-1:0]  i_addr,
  input  wire logic [15:0]              i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output logic      [15:0]              o_rdata,
  // Converter core
  input  wire logic                     i_conv_tick,
  input  wire logic [7:0]               i_chan_ready,
  input  wire logic                     i_data_taken,
  output amcr_pkg::amcr_cfg_t           o_cfg,
  output logic                          o_reset_flag,
  // Data-ready pin
  output logic                          o_data_ready_pin_out,
  output logic                          o_data_ready_pin_oe
);

  typedef struct packed {
    amcr_pkg::amcr_oper_t oper;
    amcr_pkg::amcr_clk_t  clk;
    amcr_pkg::amcr_gain_t gain;
    amcr_pkg::amcr_cfg_t  cfg;
    logic                 reset_flag;
    logic [15:0]          rdata;
    logic [1:0]           tick_sync;
    logic                 tick_prev;
    logic [7:0]           ready_prev;
  } amcr_state_t;

  amcr_state_t st_reg;
  amcr_state_t st_next;
  logic        tick_rise;
  logic [7:0]  chan_live;
  logic        src_event;

  // Word size in bits from the select code
  function automatic logic [5:0] word_bits_of(input logic [1:0] code);
    unique case (code)
      2'h0:    word_bits_of = 6'h10;
      2'h1:    word_bits_of = 6'h18;
      default: word_bits_of = 6'h20;
    endcase
  endfunction

  // Oversampling ratio; top code is not a power of two
  function automatic logic [14:0] osr_of(input logic [2:0] code);
    if (code == 3'h7) begin
      osr_of = 15'h3f80;
    end else begin
      osr_of = 15'h0080 << code;
    end
  endfunction

  // Register image packed for read-back
  function automatic logic [15:0] image_of(input amcr_state_t s, input logic [3:0] a);
    unique case (a)
      `AMCR_OFF_STAT: image_of = {5'h00, s.reset_flag, s.oper.word_size_select, 8'h00};
      `AMCR_OFF_OPER: image_of = s.oper;
      `AMCR_OFF_CLK:  image_of = s.clk;
      `AMCR_OFF_GAIN: image_of = s.gain;
      default:        image_of = 16'h0000;
    endcase
  endfunction

  // Link tick is asynchronous; two stages before use
  assign tick_rise = st_reg.tick_sync[1] && !st_reg.tick_prev;
  assign chan_live = i_chan_ready & st_reg.cfg.channel_enable;

  // Data-ready source: lagging waits for all, OR for any, leading for first
  always_comb begin
    unique case (st_reg.oper.ready_source_select)                                  // [R7]
      `AMCR_SRC_LAG: src_event = (chan_live != 8'h00) &&
                                 ((chan_live | ~st_reg.cfg.channel_enable) == 8'hff) &&
                                 ((st_reg.ready_prev | ~st_reg.cfg.channel_enable) != 8'hff);
      `AMCR_SRC_OR:  src_event = (chan_live & ~st_reg.ready_prev) != 8'h00;
      default:       src_event = (chan_live != 8'h00) && (st_reg.ready_prev == 8'h00);
    endcase
  end

  // Register writes, flag and settings update
  always_comb begin
    st_next            = st_reg;
    st_next.tick_sync  = {st_reg.tick_sync[0], i_conv_tick};
    st_next.tick_prev  = st_reg.tick_sync[1];
    st_next.ready_prev = chan_live;
    if (i_rd) begin
      st_next.rdata = image_of(st_reg, i_addr);                                    // [R21]
    end
    if (i_wr) begin
      unique case (i_addr)
        `AMCR_OFF_OPER: begin
          st_next.oper = i_wdata & `AMCR_MASK_OPER;                                // [R17] [R20]
          if (!i_wdata[`AMCR_BIT_RSTFLAG]) begin
            st_next.reset_flag = 1'b0;                                             // [R4] [R19]
          end
        end
        `AMCR_OFF_CLK:  st_next.clk  = i_wdata & `AMCR_MASK_CLK;                   // [R15] [R20]
        `AMCR_OFF_GAIN: st_next.gain = i_wdata & `AMCR_MASK_GAIN;                  // [R16] [R20]
        default: ;
      endcase
    end
    // Settings move to the core only at a conversion boundary
    if (tick_rise) begin                                                           // [R21]
      st_next.cfg.map_crc_en     = st_reg.oper.map_crc_en;                         // [R1]
      st_next.cfg.frame_crc_en   = st_reg.oper.frame_crc_en;                       // [R2]
      st_next.cfg.crc_poly_ansi  = st_reg.oper.crc_poly_ansi;                      // [R3]
      st_next.cfg.word_bits      = word_bits_of(st_reg.oper.word_size_select);     // [R5]
      st_next.cfg.word_sign_ext  = (st_reg.oper.word_size_select == 2'h3);         // [R5]
      st_next.cfg.timeout_en     = st_reg.oper.timeout_en;                         // [R6]
      st_next.cfg.channel_enable = st_reg.clk.channel_enable;                      // [R10]
      st_next.cfg.oscillator_off = st_reg.clk.oscillator_off;                      // [R11]
      st_next.cfg.outside_reference_select = st_reg.clk.outside_reference_select;  // [R12]
      st_next.cfg.osr_value      = osr_of(st_reg.clk.oversampling_ratio);          // [R13]
      st_next.cfg.power_profile  = st_reg.clk.power_profile;                       // [R14]
      for (int i = 0; i < 4; i++) begin
        st_next.cfg.amp_gain_factor[i] = 8'h01 << st_reg.gain.amp_gain[i][2:0];   // [R18]
      end
    end
  end

  // Reset image matches the documented defaults
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st_reg                     <= '0;
      st_reg.oper                <= `AMCR_RST_OPER;                                // [R17]
      st_reg.clk                 <= `AMCR_RST_CLK;                                 // [R15]
      st_reg.gain                <= `AMCR_RST_GAIN;                                // [R16]
      st_reg.reset_flag          <= 1'b1;                                          // [R19]
      st_reg.cfg.timeout_en      <= 1'b1;
      st_reg.cfg.word_bits       <= 6'h18;
      st_reg.cfg.channel_enable  <= 8'hff;
      st_reg.cfg.osr_value       <= 15'h0400;
      st_reg.cfg.power_profile   <= 2'h2;
      st_reg.cfg.amp_gain_factor <= {4{8'h01}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_rdata      = st_reg.rdata;
  assign o_cfg        = st_reg.cfg;
  assign o_reset_flag = st_reg.reset_flag;

  // Pin driver follows the live format and idle settings
  amcr_ready_pin u_ready_pin (
    .i_core_clk     (i_core_clk),
    .i_rst_n        (i_rst_n),
    .i_new_data     (src_event),
    .i_data_taken   (i_data_taken),
    .i_pulse_format (st_reg.oper.ready_pulse_format),                              // [R9]
    .i_idle_float   (st_reg.oper.ready_idle_float),                                // [R8]
    .o_pin_out      (o_data_ready_pin_out),
    .o_pin_oe       (o_data_ready_pin_oe)
  );

endmodule // amcr_regs

// ---- amcr_regs_asserts.sv ----
// Port-level checks for the configuration register bank
`include "amcr_consts.svh"
module amcr_regs_asserts (
  // Clock and reset
  input wire logic                    i_core_clk,
  input wire logic                    i_rst_n,
  // Register port
  input wire logic [`AMCR_ADDR_W-1:0] i_addr,
  input wire logic [15:0]             i_wdata,
  input wire logic                    i_wr,
  input wire logic                    i_rd,
  input wire logic [15:0]             o_rdata,
  // Status and pin
  input wire logic                    i_data_taken,
  input wire logic                    o_reset_flag,
  input wire logic                    o_data_ready_pin_out,
  input wire logic                    o_data_ready_pin_oe
);
  logic [15:0] sh_reg;
  logic        clr;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // Shadow of the operating register, rebuilt from bus writes alone
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) sh_reg <= `AMCR_RST_OPER;
    else if (i_wr && i_addr == `AMCR_OFF_OPER) sh_reg <= i_wdata & `AMCR_MASK_OPER;
  end
  assign clr = i_wr && i_addr == `AMCR_OFF_OPER && !i_wdata[`AMCR_BIT_RSTFLAG];
  sequence pulse_s;
    !o_data_ready_pin_out ##1 o_data_ready_pin_out;
  endsequence
  rst_state_a: assert property ($rose(i_rst_n) |-> o_reset_flag && o_data_ready_pin_out)
    else $error("state after reset wrong");
  flag_clear_a: assert property (clr |=> !o_reset_flag)
    else $error("reset flag not cleared");
  flag_hold_a: assert property (!clr |=> $stable(o_reset_flag))
    else $error("reset flag moved by itself");
  oper_read_a: assert property (i_rd && i_addr == `AMCR_OFF_OPER |=> o_rdata == $past(sh_reg))
    else $error("operating read value wrong");
  unmapped_read_a: assert property (i_rd && (i_addr == 4'h0 || i_addr > 4'h4) |=> o_rdata == 16'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!i_rd |=> $stable(o_rdata))
    else $error("read data moved without a read");
  drive_idle_a: assert property (!sh_reg[1] && !$past(sh_reg[1]) |-> o_data_ready_pin_oe)
    else $error("pin released while float off");
  pulse_len_a: assert property (sh_reg[0] && !sh_reg[1] && $fell(o_data_ready_pin_out) |=> pulse_s)
    else $error("ready pulse length wrong");
  level_hold_a: assert property (!sh_reg[0] && !$past(sh_reg[0]) && !o_data_ready_pin_out
    && !i_data_taken |=> !o_data_ready_pin_out)
    else $error("ready level dropped before taken");
endmodule // amcr_regs_asserts

bind amcr_regs amcr_regs_asserts amcr_regs_asserts_inst (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_data_taken(i_data_taken),
  .o_reset_flag(o_reset_flag), .o_data_ready_pin_out(o_data_ready_pin_out),
  .o_data_ready_pin_oe(o_data_ready_pin_oe));

// ---- amcr_regs_bench.sv ----
// Self-checking bench for the configuration register bank
module amcr_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, wr, rd, go, taken, tick, flag, pin, oe;
  logic [3:0] addr;
  logic [7:0] rdy;
  logic [15:0] wdata, rdata, d, oper, clkr, gain;
  amcr_pkg::amcr_cfg_t cfg;
  int n_fail, tests_run, seed, i, j;
  amcr_regs amcr_regs_inst (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_conv_tick(tick),
    .i_chan_ready(rdy), .i_data_taken(taken), .o_cfg(cfg), .o_reset_flag(flag),
    .o_data_ready_pin_out(pin), .o_data_ready_pin_oe(oe));
  amcr_core_model amcr_core_model_inst (.i_core_clk(clk), .i_go(go), .i_taken(taken),
    .o_tick(tick), .o_ready(rdy));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr_t(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task rd_t(input logic [3:0] a, input logic [15:0] e, input string nm);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 chk(nm, rdata, e);
  endtask
  // Host hands a one-cycle request to the core
  task pulse_t(input int sel, input int wait_n);
    @(posedge clk); if (sel) taken <= 1'b1; else go <= 1'b1;
    @(posedge clk); taken <= 1'b0; go <= 1'b0;
    repeat (wait_n) @(posedge clk);
  endtask
  task results;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [5:0] wbits(input logic [1:0] w);
    return (w == 2'h0) ? 6'd16 : (w == 2'h1) ? 6'd24 : 6'd32;
  endfunction
  function automatic logic [14:0] osrv(input logic [2:0] c);
    return (c == 3'h7) ? 15'd16256 : (15'd128 << c);
  endfunction
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Watchdog well beyond the expected run
  initial begin
    #300000;
    n_fail++;
    results();
  end
  initial begin
    seed = 74; rst_n = 1'b0; wr = 1'b0; rd = 1'b0; go = 1'b0; taken = 1'b0;
    addr = 4'h0; wdata = 16'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_t(4'h2, 16'h0510, "oper_rst");
    rd_t(4'h3, 16'hff0e, "clk_rst");
    rd_t(4'h4, 16'h0000, "gain_rst");
    chk("flag_rst", flag, 1'b1);
    rd_t(4'h1, 16'h0500, "stat_rst");
    rd_t(4'h0, 16'h0, "unmapped0");
    rd_t(4'h9, 16'h0, "unmapped9");
    for (i = 0; i < 40; i++) begin
      oper = 16'($random(seed)) & 16'h3f1f;
      clkr = 16'($random(seed)) & 16'hffdf;
      gain = 16'($random(seed)) & 16'h7777;
      if (i < 8) begin
        clkr[4:2] = i[2:0];
        gain = {4{1'b0, i[2:0]}};
        oper[9:8] = i[1:0];
      end
      wr_t(4'h2, oper); wr_t(4'h3, clkr); wr_t(4'h4, gain);
      rd_t(4'h2, oper, "oper");
      rd_t(4'h3, clkr, "clk");
      rd_t(4'h4, gain, "gain");
      @(posedge tick); repeat (8) @(posedge clk);
      chk("wbits", cfg.word_bits, wbits(oper[9:8]));
      chk("sext", cfg.word_sign_ext, oper[9:8] == 2'h3);
      chk("crc", {cfg.map_crc_en, cfg.frame_crc_en, cfg.crc_poly_ansi}, oper[13:11]);
      chk("tmo", cfg.timeout_en, oper[4]);
      chk("clkf", {cfg.channel_enable, cfg.oscillator_off, cfg.outside_reference_select,
        cfg.power_profile}, {clkr[15:6], clkr[1:0]});
      chk("osr", cfg.osr_value, osrv(clkr[4:2]));
      for (j = 0; j < 4; j++) chk("gainf", cfg.amp_gain_factor[j], 8'h01 << gain[4*j+:3]);
    end
    // Reserved bits read back as zero
    wr_t(4'h2, 16'hffff); rd_t(4'h2, 16'h3f1f, "oper_rsv");
    wr_t(4'h3, 16'hffff); rd_t(4'h3, 16'hffdf, "clk_rsv");
    wr_t(4'h4, 16'hffff); rd_t(4'h4, 16'h7777, "gain_rsv");
    wr_t(4'h3, 16'hff0e);
    wr_t(4'h2, 16'h0014); #1 chk("flag_clr", flag, 1'b0);
    rd_t(4'h1, 16'h0000, "stat_clr");
    // OR source: low soon after first channel, held until taken
    pulse_t(0, 4); chk("or_low", pin, 1'b0);
    repeat (10) @(posedge clk); chk("lvl_hold", pin, 1'b0);
    pulse_t(1, 3); chk("taken_hi", pin, 1'b1);
    // Lagging source waits for all eight channels
    wr_t(4'h2, 16'h0010);
    pulse_t(0, 2); chk("lag_wait", pin, 1'b1);
    repeat (12) @(posedge clk); chk("lag_low", pin, 1'b0);
    pulse_t(1, 3);
    wr_t(4'h2, 16'h0011); pulse_t(0, 14); pulse_t(1, 3);
    wr_t(4'h2, 16'h0012); repeat (3) @(posedge clk); chk("float", oe, 1'b0);
    // Leading source in pulse format: low for two cycles, from one cycle after the first channel
    wr_t(4'h2, 16'h0019);
    pulse_t(0, 1); #1 chk("lead_lo0", pin, 1'b0);
    @(posedge clk); #1 chk("lead_lo1", pin, 1'b0);
    @(posedge clk); #1 chk("lead_end", pin, 1'b1);
    pulse_t(1, 3);
    results();
  end
endmodule // amcr_regs_bench
